// file: rtl/ext_bus_master.sv
`timescale 1ns/1ps
`include "ext_bus_params.svh"
// What this block does
// - In the wait state the acknowledge is sampled at each rising edge and whole wait cycles are added until it is seen.
// - With automatic acknowledge enabled the block makes the acknowledge itself.
// - After acknowledge the acknowledge is negated, by the peripheral or by the internal logic.
// - The chip select is negated on the falling clock edge inside the release state.
// - In the release state the address stops being driven, ending the cycle; RW_OUT has no enable and keeps its level.
// - Data drivers go to high impedance at the rising edge closing the release state, unless a write starts back to back.
// - The edge ending the release state may start the next access with no idle cycle.
// - Consecutive cycles run back to back whenever a request is pending.
// - A longword read to a 16-bit port without burst reads becomes two back-to-back word reads.
// - Any mix of reads and writes may run back to back.
// - Back-to-back starts are decided by the bus logic alone, with no software control.
module ext_bus_master (
    input  wire logic        CLK_IN,
    input  wire logic        RESET_N_IN,
    input  wire logic        REQ_VALID_IN,
    input  wire logic        REQ_WRITE_IN,
    input  wire logic [1:0]  REQ_SIZE_IN,
    input  wire logic [31:0] REQ_ADDR_IN,
    input  wire logic [31:0] REQ_WDATA_IN,
    input  wire logic        AUTO_ACK_EN_IN,
    input  wire logic        PORT_16BIT_IN,
    input  wire logic        BURST_READ_EN_IN,
    input  wire logic        TRANSFER_ACK_N_IN,
    input  wire logic [31:0] DATA_IN,
    output logic             REQ_READY_OUT,
    output logic             RESP_VALID_OUT,
    output logic [31:0]      RESP_RDATA_OUT,
    output logic             CHIP_SEL_N_OUT,
    output logic [31:0]      ADDR_OUT,
    output logic             ADDR_OE_N_OUT,
    output logic             RW_OUT,
    output logic [31:0]      DATA_OUT,
    output logic             DATA_OE_N_OUT
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic ack_meta;
    logic ack_sync;
    logic [31:0] din_meta;
    logic [31:0] din_sync;
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ack_meta <= 1'b1;
            ack_sync <= 1'b1;
            din_meta <= `DATA_RESET;
            din_sync <= `DATA_RESET;
        end else begin
            ack_meta <= TRANSFER_ACK_N_IN;
            ack_sync <= ack_meta;
            din_meta <= DATA_IN;
            din_sync <= din_meta;
        end
    end

    // ------------------------------------------------------------
    // Cycle sequencer
    // ------------------------------------------------------------
    ext_bus_pkg::bus_state_e state;
    ext_bus_pkg::bus_state_e next_state;
    logic        second_half;
    logic        next_second_half;
    logic [31:0] addr;
    logic [31:0] next_addr;
    logic        rw_write;
    logic        next_rw_write;
    logic [31:0] wdata;
    logic [31:0] next_wdata;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        resp_valid;
    logic        next_resp_valid;
    logic        ready;
    logic        next_ready;
    logic        cs_rise;
    logic        next_cs_rise;
    logic        drive;
    logic        next_drive;
    logic        ddrive;
    logic        next_ddrive;
    logic        ack_seen;
    logic        split;
    logic        in_tail;
    logic        next_in_tail;
    logic        wait_cycle;
    logic        next_wait_cycle;
    logic        addr_oe_n;
    logic        next_addr_oe_n;
    logic        rw_read;
    logic        next_rw_read;
    logic        data_oe_n;
    logic        next_data_oe_n;

    // Internal acknowledge answers in the second wait cycle, because read data
    // needs that long to pass the pin synchroniser; it is never held beyond
    // that state, so it is negated automatically afterwards.
    assign ack_seen = AUTO_ACK_EN_IN ? (state == ext_bus_pkg::ST_WAIT_ACK) && wait_cycle
                                     : !ack_sync;
    assign split = !REQ_WRITE_IN && (REQ_SIZE_IN == `SIZE_LONG)
                   && PORT_16BIT_IN && !BURST_READ_EN_IN;

    always_comb begin
        next_state       = state;
        next_second_half = second_half;
        next_addr        = addr;
        next_rw_write    = rw_write;
        next_wdata       = wdata;
        next_rdata       = rdata;
        next_resp_valid  = 1'b0;
        next_ready       = 1'b0;
        next_cs_rise     = 1'b0;
        next_drive       = drive;
        next_ddrive      = ddrive;
        next_in_tail     = in_tail;
        next_wait_cycle  = 1'b0;
        unique case (state)
            ext_bus_pkg::ST_IDLE: begin
                next_drive  = 1'b0;
                next_ddrive = 1'b0;
                if (REQ_VALID_IN) begin
                    next_state       = ext_bus_pkg::ST_ADDR;
                    next_addr        = REQ_ADDR_IN;
                    next_rw_write    = REQ_WRITE_IN;
                    next_wdata       = REQ_WDATA_IN;
                    next_second_half = split;
                    next_in_tail     = 1'b0;
                    next_ready       = 1'b1;
                    next_drive       = 1'b1;
                    next_ddrive      = REQ_WRITE_IN;
                end
            end
            ext_bus_pkg::ST_ADDR: begin
                next_state = ext_bus_pkg::ST_WAIT_ACK;
            end
            ext_bus_pkg::ST_WAIT_ACK: begin
                next_wait_cycle = !ack_seen;
                if (ack_seen) begin
                    next_state = ext_bus_pkg::ST_ACK_DONE;
                    if (!rw_write) begin
                        next_rdata = in_tail ? {din_sync[15:0], rdata[15:0]}
                                             : din_sync;
                    end
                end
            end
            ext_bus_pkg::ST_ACK_DONE: begin
                next_state   = ext_bus_pkg::ST_RELEASE;
                next_cs_rise = 1'b1;
                next_drive   = 1'b0;
            end
            ext_bus_pkg::ST_RELEASE: begin
                next_ddrive = 1'b0;
                if (second_half) begin
                    next_state       = ext_bus_pkg::ST_ADDR;
                    next_second_half = 1'b0;
                    next_in_tail     = 1'b1;
                    next_addr        = addr + `WORD_STEP;
                    next_drive       = 1'b1;
                end else begin
                    next_resp_valid = !rw_write;
                    if (REQ_VALID_IN) begin
                        next_state       = ext_bus_pkg::ST_ADDR;
                        next_addr        = REQ_ADDR_IN;
                        next_rw_write    = REQ_WRITE_IN;
                        next_wdata       = REQ_WDATA_IN;
                        next_second_half = split;
                        next_in_tail     = 1'b0;
                        next_ready       = 1'b1;
                        next_drive       = 1'b1;
                        next_ddrive      = REQ_WRITE_IN;
                    end else begin
                        next_state = ext_bus_pkg::ST_IDLE;
                    end
                end
            end
            default: next_state = ext_bus_pkg::ST_IDLE;
        endcase
        next_addr_oe_n = !next_drive;
        next_rw_read   = !next_rw_write;
        next_data_oe_n = !next_ddrive;
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            state       <= ext_bus_pkg::ST_IDLE;
            second_half <= 1'b0;
            addr        <= `ADDR_RESET;
            rw_write    <= 1'b0;
            wdata       <= `DATA_RESET;
            rdata       <= `DATA_RESET;
            resp_valid  <= 1'b0;
            ready       <= 1'b0;
            cs_rise     <= 1'b0;
            drive       <= 1'b0;
            ddrive      <= 1'b0;
            in_tail     <= 1'b0;
            wait_cycle  <= 1'b0;
            addr_oe_n   <= 1'b1;
            rw_read     <= 1'b1;
            data_oe_n   <= 1'b1;
        end else begin
            state       <= next_state;
            second_half <= next_second_half;
            addr        <= next_addr;
            rw_write    <= next_rw_write;
            wdata       <= next_wdata;
            rdata       <= next_rdata;
            resp_valid  <= next_resp_valid;
            ready       <= next_ready;
            cs_rise     <= next_cs_rise;
            drive       <= next_drive;
            ddrive      <= next_ddrive;
            in_tail     <= next_in_tail;
            wait_cycle  <= next_wait_cycle;
            addr_oe_n   <= next_addr_oe_n;
            rw_read     <= next_rw_read;
            data_oe_n   <= next_data_oe_n;
        end
    end

    // ------------------------------------------------------------
    // Chip select on the falling edge
    // ------------------------------------------------------------
    // A falling-edge flop lets the select drop half a cycle into the
    // release state, after the rising-edge address hold.
    logic cs_n;
    always_ff @(negedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            cs_n <= 1'b1;
        end else begin
            cs_n <= !(drive && !cs_rise) && !(state == ext_bus_pkg::ST_ADDR);
        end
    end

    assign REQ_READY_OUT  = ready;
    assign RESP_VALID_OUT = resp_valid;
    assign RESP_RDATA_OUT = rdata;
    assign CHIP_SEL_N_OUT = cs_n;
    assign ADDR_OUT       = addr;
    assign ADDR_OE_N_OUT  = addr_oe_n;
    assign RW_OUT         = rw_read;
    assign DATA_OUT       = wdata;
    assign DATA_OE_N_OUT  = data_oe_n;
endmodule : ext_bus_master

// file: rtl/ext_bus_params.svh
`ifndef EXT_BUS_PARAMS_SVH
`define EXT_BUS_PARAMS_SVH
`define ADDR_RESET      32'h0000_0000
`define DATA_RESET      32'h0000_0000
`define SIZE_LONG       2'h2
`define SIZE_WORD       2'h1
`define WORD_STEP       32'h0000_0002
`endif

// file: rtl/ext_bus_pkg.sv
package ext_bus_pkg;
    typedef enum logic [2:0] {
        ST_IDLE     = 3'h0,
        ST_ADDR     = 3'h1,
        ST_WAIT_ACK = 3'h3,
        ST_ACK_DONE = 3'h2,
        ST_RELEASE  = 3'h6
    } bus_state_e;
endpackage : ext_bus_pkg

// file: verification/ext_bus_peripheral.sv
`timescale 1ns/1ps
module ext_bus_peripheral (
    input  wire logic        clk_in,
    input  wire logic        cs_n_in,
    input  wire logic        rw_in,
    input  wire logic        auto_in,
    input  wire logic [3:0]  wait_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [31:0] wdata_in,
    output logic             ack_n_out = 1'b1,
    output logic [31:0]      rdata_out,
    output logic             wr_stb_out,
    output logic [63:0]      wr_out
);
    logic [7:0]  cnt = 8'h00;
    logic [31:0] pat = 32'h0;
    wire hit = !cs_n_in && cnt == (auto_in ? 8'h00 : {4'h0, wait_in});
    // A released bus shows a moving pattern, never the last value.
    assign rdata_out = !cs_n_in && rw_in ? ~addr_in ^ 32'h3C96_A55A : pat;
    always @(posedge clk_in) begin
        cnt        <= cs_n_in ? 8'h00 : cnt + 8'h01;
        pat        <= pat + 32'h1357_9BDF;
        ack_n_out  <= !(hit && !auto_in);
        wr_stb_out <= hit && !rw_in;
        wr_out     <= {addr_in, wdata_in};
    end
endmodule : ext_bus_peripheral

// file: verification/ext_bus_props.sv
`timescale 1ns/1ps
module ext_bus_props (
    input wire logic        CLK_IN,
    input wire logic        RESET_N_IN,
    input wire logic        REQ_VALID_IN,
    input wire logic        AUTO_ACK_EN_IN,
    input wire logic        TRANSFER_ACK_N_IN,
    input wire logic        CHIP_SEL_N_OUT,
    input wire logic [31:0] ADDR_OUT,
    input wire logic        ADDR_OE_N_OUT,
    input wire logic        RW_OUT,
    input wire logic [31:0] DATA_OUT,
    input wire logic        DATA_OE_N_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);
    a_addr_stable: assert property (
        !CHIP_SEL_N_OUT && !ADDR_OE_N_OUT && $past(!CHIP_SEL_N_OUT)
        |-> $stable(ADDR_OUT) && $stable(RW_OUT)) else $error("address moved");
    a_data_stable: assert property (
        !CHIP_SEL_N_OUT && !DATA_OE_N_OUT && $past(!CHIP_SEL_N_OUT)
        |-> $stable(DATA_OUT)) else $error("data moved");
    a_cs_release: assert property (
        $rose(CHIP_SEL_N_OUT) |-> ADDR_OE_N_OUT) else $error("address held");
    a_data_hiz: assert property (
        $rose(CHIP_SEL_N_OUT) && !REQ_VALID_IN |=> DATA_OE_N_OUT) else $error("data held");
    a_read_no_drive: assert property (
        RW_OUT && !ADDR_OE_N_OUT |-> DATA_OE_N_OUT) else $error("drive on read");
    a_ack_wait: assert property (
        $fell(CHIP_SEL_N_OUT) ##0 (TRANSFER_ACK_N_IN && !AUTO_ACK_EN_IN)[*4]
        |-> !CHIP_SEL_N_OUT) else $error("ended without ack");
    a_auto_ack: assert property (
        $fell(CHIP_SEL_N_OUT) && AUTO_ACK_EN_IN |-> ##[1:4] $rose(CHIP_SEL_N_OUT))
        else $error("auto ack missing");
    a_back_to_back: assert property (
        $rose(CHIP_SEL_N_OUT) && REQ_VALID_IN |-> ##1 $fell(CHIP_SEL_N_OUT))
        else $error("idle gap");
    c_b2b: cover property ($rose(CHIP_SEL_N_OUT) ##1 $fell(CHIP_SEL_N_OUT));
    c_auto: cover property ($fell(CHIP_SEL_N_OUT) && AUTO_ACK_EN_IN);
    c_wait: cover property ($fell(CHIP_SEL_N_OUT) ##0 TRANSFER_ACK_N_IN[*4]);
endmodule : ext_bus_props
bind ext_bus_master ext_bus_props u_props (.CLK_IN, .RESET_N_IN, .REQ_VALID_IN,
    .AUTO_ACK_EN_IN, .TRANSFER_ACK_N_IN, .CHIP_SEL_N_OUT, .ADDR_OUT, .ADDR_OE_N_OUT,
    .RW_OUT, .DATA_OUT, .DATA_OE_N_OUT);

// file: verification/tb.sv
`timescale 1ns/1ps
`include "ext_bus_params.svh"
module tb;
    logic        clk = 1'b0, rst_n = 1'b0, vld = 1'b0, wr = 1'b0;
    logic        auto = 1'b0, p16 = 1'b0, brst = 1'b0;
    logic [3:0]  wt = 4'h0;
    logic [1:0]  sz = `SIZE_LONG;
    logic [31:0] addr = 32'h0, wdata = 32'h0, rdata, a_out, d_out, d_in;
    logic        ack_n, ready, rvalid, cs_n, a_oe_n, rw, d_oe_n, wstb;
    logic [63:0] wrec;
    logic [31:0] rq[$];
    logic [63:0] wq[$];
    integer      seed = 32'h88f9358b;
    int          fails = 0, samples_checked = 0;
    always #25 clk = ~clk;
    ext_bus_master dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(vld),
        .REQ_WRITE_IN(wr), .REQ_SIZE_IN(sz), .REQ_ADDR_IN(addr), .REQ_WDATA_IN(wdata),
        .AUTO_ACK_EN_IN(auto), .PORT_16BIT_IN(p16), .BURST_READ_EN_IN(brst),
        .TRANSFER_ACK_N_IN(ack_n), .DATA_IN(d_in), .REQ_READY_OUT(ready),
        .RESP_VALID_OUT(rvalid), .RESP_RDATA_OUT(rdata), .CHIP_SEL_N_OUT(cs_n),
        .ADDR_OUT(a_out), .ADDR_OE_N_OUT(a_oe_n), .RW_OUT(rw), .DATA_OUT(d_out),
        .DATA_OE_N_OUT(d_oe_n));
    ext_bus_peripheral peer (.clk_in(clk), .cs_n_in(cs_n), .rw_in(rw), .auto_in(auto),
        .wait_in(wt), .addr_in(a_out), .wdata_in(d_out), .ack_n_out(ack_n),
        .rdata_out(d_in), .wr_stb_out(wstb), .wr_out(wrec));
    task automatic check_read(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t read got=%h exp=%h", $time, got, exp);
        end
    endtask : check_read
    task automatic check_write(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t write got=%h exp=%h", $time, got, exp);
        end
    endtask : check_write
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    always @(negedge clk) begin
        if (rvalid === 1'b1) check_read(rdata, rq.pop_front());
        if (wstb === 1'b1) check_write(wrec, wq.pop_front());
    end
    // Requests follow each other at once, so reads and writes mix back to back.
    task automatic send(input int n);
        logic [31:0] a, d, r0, r1;
        logic        w;
        logic [1:0]  s;
        int          k;
        for (int i = 0; i < n; i++) begin
            a = $random(seed) & 32'hFFFF_FFFC;
            d = $random(seed);
            w = 1'($random(seed));
            s = ($random(seed) & 32'h1) != 32'h0 ? `SIZE_WORD : `SIZE_LONG;
            r0 = ~a ^ 32'h3C96_A55A;
            r1 = ~(a + `WORD_STEP) ^ 32'h3C96_A55A;
            if (w) wq.push_back({a, d});
            else rq.push_back(s == `SIZE_LONG && p16 && !brst
                              ? {r1[15:0], r0[15:0]} : r0);
            vld <= 1'b1;
            wr <= w;
            sz <= s;
            addr <= a;
            wdata <= d;
            k = 0;
            do @(negedge clk); while (ready !== 1'b1 && ++k < 200);
            @(posedge clk);
            if (k >= 200) fails++;
        end
        vld <= 1'b0;
    endtask : send
    initial begin
        #(5000 * 50);
        fails++;
        close_out();
    end
    initial begin
        int k;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            {brst, p16, auto} <= c[2:0];
            wt <= c[3] ? 4'h6 : 4'h0;
            // The expectations read the new mode, so it must have settled first.
            @(posedge clk);
            send(6);
            k = 0;
            do @(negedge clk); while ((rq.size() + wq.size() > 0 || cs_n !== 1'b1) && ++k < 200);
            if (k >= 200) fails++;
        end
        close_out();
    end
endmodule : tb
